// file: wit_pkg.sv
// Constants for the watch and interval timer: register offset, field layout, widths.
// Assumes a byte-wide CPU register space addressed by 16-bit addresses.
package wit_pkg;
  localparam logic [15:0] WIT_CTRL_ADDR = 16'hff6f;
  localparam logic [7:0] WIT_CTRL_RESET = 8'h00;
  localparam int WIT_BIT_ENABLE = 0;
  localparam int WIT_BIT_RUN = 1;
  localparam int WIT_WSEL_LO = 2;
  localparam int WIT_WSEL_HI = 3;
  localparam int WIT_ISEL_LO = 4;
  localparam int WIT_ISEL_HI = 6;
  localparam int WIT_BIT_CLKSEL = 7;
  localparam int WIT_PRESCALER_W = 11;
  localparam int WIT_COUNTER_W = 5;
  localparam int WIT_MAIN_DIV_W = 7;
  localparam int WIT_ISEL_BASE = 4;
  localparam int WIT_WATCH_TAP = 9;
  localparam int WIT_WATCH_SHORT_TAP = 4;
  localparam int WIT_WATCH_MID_BITS = 4;
  localparam int WIT_TAP_LEN_W = 5;
  typedef enum logic [1:0]
  {
    WIT_WSEL_2P14 = 2'b00,
    WIT_WSEL_2P13 = 2'b01,
    WIT_WSEL_2P5 = 2'b10,
    WIT_WSEL_2P4 = 2'b11
  } wit_wsel_t;
endpackage

// file: wit_tap.sv
// Overflow detector: pulses when the low len_i bits of a counter are all ones on a step.
// Assumes the counter advances by one exactly when step_i is high.
module wit_tap
  import wit_pkg::*;
#(
  parameter int W = 11
)
(
  input wire logic [W-1:0] value_i,
  input wire logic [WIT_TAP_LEN_W-1:0] len_i,
  input wire logic step_i,
  output logic hit_o
);
  logic [W-1:0] mask;

  initial
  begin
    if (W < 1 || W > 31)
      $error("wit_tap width out of range");
  end

  always_comb
  begin
    mask = '0;
    for (int i = 0; i < W; i++)
    begin
      if (i < int'(len_i))
        mask[i] = 1'b1;
    end
    hit_o = step_i && ((value_i & mask) == mask);
  end
endmodule

// file: wit_top.sv
// Watch and interval timer with its byte-wide control register.
// Assumes the oscillator tick inputs are one-cycle pulses synchronous to clk_i.
// How it works
// - clock-select bit picks main/128 or subsystem
// - prescaler bits 4-6 select interval 2^4..2^11
// - bits 3:2 select watch period
// - bit 1 runs or clears 5-bit counter
// - bit 0 low clears prescaler and counter
// - watch interrupts only with both enables set
// - clearing bit 1 leaves prescaler running
// - interval interrupt repeats whenever bit 0 set
// - counter starts at next prescaler output
// - reset clears register; bit and byte writes
module wit_top
  import wit_pkg::*;
#(
  parameter int PRESCALER_W = WIT_PRESCALER_W,
  parameter int COUNTER_W = WIT_COUNTER_W
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic main_osc_tick_i,
  input wire logic sub_osc_tick_i,
  input wire logic [15:0] addr_i,
  input wire logic byte_wr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic bit_wr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic bit_val_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  output logic watch_irq_o,
  output logic interval_irq_o
);
  logic [7:0] watch_mode_control_reg;
  logic [7:0] watch_mode_control_next;
  logic [WIT_MAIN_DIV_W-1:0] main_div_reg;
  logic [PRESCALER_W-1:0] prescaler_reg;
  logic [COUNTER_W-1:0] counter_reg;
  logic watch_count_clock;
  logic timer_enable;
  logic counter_run;
  logic count_clock_select;
  logic [2:0] interval_select;
  wit_wsel_t watch_period_select;
  logic fw_step;
  logic interval_hit;
  logic counter_step;
  logic counter_full_hit;
  logic counter_mid_hit;
  logic short_hit;
  logic watch_hit;
  logic [WIT_TAP_LEN_W-1:0] interval_len;
  logic [WIT_TAP_LEN_W-1:0] short_len;
  logic sel_addr;

  initial
  begin
    if (PRESCALER_W != WIT_PRESCALER_W || COUNTER_W != WIT_COUNTER_W)
      $error("wit_top widths must match the fixed period table");
    if (WIT_ISEL_BASE + 7 > PRESCALER_W)
      $error("wit_top interval taps exceed the prescaler");
    if (WIT_WATCH_TAP >= PRESCALER_W || WIT_WATCH_MID_BITS >= COUNTER_W)
      $error("wit_top watch taps exceed the counters");
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  assign sel_addr = (addr_i == WIT_CTRL_ADDR);
  assign timer_enable = watch_mode_control_reg[WIT_BIT_ENABLE];
  assign counter_run = watch_mode_control_reg[WIT_BIT_RUN];
  assign count_clock_select = watch_mode_control_reg[WIT_BIT_CLKSEL];
  assign interval_select = watch_mode_control_reg[WIT_ISEL_HI:WIT_ISEL_LO];
  assign watch_period_select = wit_wsel_t'(watch_mode_control_reg[WIT_WSEL_HI:WIT_WSEL_LO]);

  // A byte write wins over a bit write that arrives in the same cycle.
  always_comb
  begin
    watch_mode_control_next = watch_mode_control_reg;
    if (sel_addr && byte_wr_i)
    begin
      watch_mode_control_next = wr_data_i;
    end
    else if (sel_addr && bit_wr_i)
    begin
      watch_mode_control_next[bit_sel_i] = bit_val_i;
    end
  end

  // Bits 4 to 7 are not guarded; changing them mid-count just skews one period.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      watch_mode_control_reg <= WIT_CTRL_RESET;
    else
      watch_mode_control_reg <= watch_mode_control_next;
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  // Other addresses read as zero so several blocks can share one OR-ed read bus.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rd_data_o <= 8'h00;
    else if (rd_i && sel_addr)
      rd_data_o <= watch_mode_control_reg;
    else
      rd_data_o <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Count clock
  // ----------------------------------------------------------------
  // The main divider runs free so a clock-select change never restarts it.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      main_div_reg <= '0;
    else if (main_osc_tick_i)
      main_div_reg <= main_div_reg + 1'b1;
  end

  assign watch_count_clock = count_clock_select ? sub_osc_tick_i
                           : (main_osc_tick_i && (&main_div_reg));
  assign fw_step = watch_count_clock && timer_enable;

  // ----------------------------------------------------------------
  // Prescaler and interval interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      prescaler_reg <= '0;
    else if (!timer_enable)
      prescaler_reg <= '0;
    else if (fw_step)
      prescaler_reg <= prescaler_reg + 1'b1;
  end

  // One tap module serves every period, so the select only sets a mask length.
  assign interval_len = WIT_TAP_LEN_W'(WIT_ISEL_BASE) + WIT_TAP_LEN_W'(interval_select);

  wit_tap #(.W(PRESCALER_W)) u_interval_tap
  (
    .value_i(prescaler_reg),
    .len_i(interval_len),
    .step_i(fw_step),
    .hit_o(interval_hit)
  );

  wit_tap #(.W(PRESCALER_W)) u_counter_tap
  (
    .value_i(prescaler_reg),
    .len_i(WIT_TAP_LEN_W'(WIT_WATCH_TAP)),
    .step_i(fw_step),
    .hit_o(counter_step)
  );

  // ----------------------------------------------------------------
  // Watch counter and watch interrupt
  // ----------------------------------------------------------------
  // The counter only moves on a prescaler output, so the first watch period
  // after start can run short by up to one such output.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      counter_reg <= '0;
    else if (!timer_enable || !counter_run)
      counter_reg <= '0;
    else if (counter_step)
      counter_reg <= counter_reg + 1'b1;
  end

  assign counter_full_hit = counter_step && (&counter_reg);
  assign counter_mid_hit = counter_step && (&counter_reg[WIT_WATCH_MID_BITS-1:0]);
  // Codes 10 and 11 tap the prescaler directly, so they still need the run bit.
  assign short_len = (watch_period_select == WIT_WSEL_2P5)
                   ? WIT_TAP_LEN_W'(WIT_WATCH_SHORT_TAP + 1)
                   : WIT_TAP_LEN_W'(WIT_WATCH_SHORT_TAP);

  wit_tap #(.W(PRESCALER_W)) u_short_tap
  (
    .value_i(prescaler_reg),
    .len_i(short_len),
    .step_i(fw_step),
    .hit_o(short_hit)
  );

  always_comb
  begin
    case (watch_period_select)
      WIT_WSEL_2P14: watch_hit = counter_full_hit;
      WIT_WSEL_2P13: watch_hit = counter_mid_hit;
      default: watch_hit = short_hit;
    endcase
  end

  // ----------------------------------------------------------------
  // Interrupt pulses
  // ----------------------------------------------------------------
  // Both requests leave flip-flops so a tap decode never glitches onto them.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      watch_irq_o <= 1'b0;
    else
      watch_irq_o <= watch_hit && timer_enable && counter_run;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      interval_irq_o <= 1'b0;
    else
      interval_irq_o <= interval_hit;
  end
endmodule

// file: wit_top_properties.sv
// Port checker for the watch and interval timer.
// Assumes it is bound to wit_top and sees only that module's ports.
module wit_top_properties
  import wit_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic main_osc_tick_i,
  input wire logic sub_osc_tick_i,
  input wire logic [15:0] addr_i,
  input wire logic byte_wr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic bit_wr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic bit_val_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic watch_irq_o,
  input wire logic interval_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctl_reg;
  wire logic hit = addr_i == WIT_CTRL_ADDR;
  // Shadow copy of the control register, so gating can be judged.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      ctl_reg <= 8'h00;
    else if (byte_wr_i && hit)
      ctl_reg <= wr_data_i;
    else if (bit_wr_i && hit)
      ctl_reg[bit_sel_i] <= bit_val_i;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_read_value:
    assert property (rd_i && hit && !byte_wr_i && !bit_wr_i |=> rd_data_o == ctl_reg)
    else $error("read data differs");
  a_read_idle:
    assert property (!(rd_i && hit) |=> rd_data_o == 8'h00) else $error("read data not zero");
  a_interval_pulse_gap:
    assert property (interval_irq_o |=> !interval_irq_o [*8]) else $error("interval pulse long");
  a_watch_pulse_gap:
    assert property (watch_irq_o |=> !watch_irq_o [*8]) else $error("watch pulse long");
  a_stop_quiet:
    assert property (!ctl_reg[0] |=> !interval_irq_o && !watch_irq_o) else $error("irq stopped");
  a_watch_needs_run:
    assert property (!ctl_reg[1] |=> !watch_irq_o) else $error("watch irq without run");
  a_interval_sub_tick:
    assert property (interval_irq_o && ctl_reg[7] |-> $past(sub_osc_tick_i))
    else $error("interval irq without tick");
  a_watch_sub_tick:
    assert property (watch_irq_o && ctl_reg[7] |-> $past(sub_osc_tick_i))
    else $error("watch irq without tick");
  c_interval: cover property (interval_irq_o);
  c_watch: cover property (watch_irq_o);
  c_read: cover property (rd_i && hit);
endmodule

// file: wit_top_test.sv
// Testbench for the watch and interval timer: register calls and period checks.
// Assumes a tick every clock, so a subsystem count clock period is one clock cycle and a main/128 one is 128.
module wit_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import wit_pkg::*;
  logic clk_i, sys_rst_i, main_osc_tick_i, sub_osc_tick_i, byte_wr_i, bit_wr_i;
  logic bit_val_i, rd_i, watch_irq_o, interval_irq_o, pick;
  logic [15:0] addr_i;
  logic [7:0] wr_data_i, rd_data_o;
  logic [2:0] bit_sel_i;
  int n_mismatch = 0;
  int total_checks = 0;
  int wexp[4] = '{16384, 8192, 32, 16};
  wire logic seen = pick ? watch_irq_o : interval_irq_o;
  wit_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .main_osc_tick_i(main_osc_tick_i),
    .sub_osc_tick_i(sub_osc_tick_i), .addr_i(addr_i), .byte_wr_i(byte_wr_i),
    .wr_data_i(wr_data_i), .bit_wr_i(bit_wr_i), .bit_sel_i(bit_sel_i), .bit_val_i(bit_val_i),
    .rd_i(rd_i), .rd_data_o(rd_data_o), .watch_irq_o(watch_irq_o),
    .interval_irq_o(interval_irq_o));
  initial
  begin
    clk_i = 0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic step;
    @(posedge clk_i) #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr_i = a;
    wr_data_i = d;
    byte_wr_i = 1;
    step;
    byte_wr_i = 0;
    step;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    addr_i = a;
    rd_i = 1;
    step;
    rd_i = 0;
    check(rd_data_o, e);
    step;
  endtask
  // Waits for one pulse, then counts the cycles up to the next one.
  task automatic period(input logic w, input int e);
    int n;
    pick = w;
    for (n = 0; n < 40000 && seen !== 1'b1; n++) step;
    step;
    for (n = 1; n < 40000 && seen !== 1'b1; n++) step;
    check(n, e);
  endtask
  initial
  begin
    #(90000 * 50);
    n_mismatch++;
    finish_test;
  end
  initial
  begin
    {sys_rst_i, sub_osc_tick_i} = 2'b11;
    {main_osc_tick_i, byte_wr_i, bit_wr_i, bit_val_i, rd_i, pick} = 6'h00;
    {addr_i, wr_data_i, bit_sel_i} = 27'h0;
    repeat (6) @(posedge clk_i);
    #1 sys_rst_i = 0;
    rd(WIT_CTRL_ADDR, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(WIT_CTRL_ADDR, 8'h80 | 8'(i << 4));
      wr(WIT_CTRL_ADDR, 8'h81 | 8'(i << 4));
      period(0, 1 << (i + 4));
    end
    $display("interval test done");
    for (int w = 0; w < 4; w++)
    begin
      wr(WIT_CTRL_ADDR, 8'h80 | 8'(w << 2));
      wr(WIT_CTRL_ADDR, 8'h83 | 8'(w << 2));
      period(1, wexp[w]);
    end
    $display("watch test done");
    {bit_sel_i, bit_val_i, bit_wr_i} = 5'b00101;
    step;
    bit_wr_i = 0;
    rd(WIT_CTRL_ADDR, 8'h8d);
    period(0, 16);
    $display("run clear test done");
    wr(WIT_CTRL_ADDR, 8'h00);
    {sub_osc_tick_i, main_osc_tick_i} = 2'b01;
    wr(WIT_CTRL_ADDR, 8'h01);
    period(0, 2048);
    wr(16'hff6e, 8'hff);
    rd(WIT_CTRL_ADDR, 8'h01);
    rd(16'hff6e, 8'h00);
    sys_rst_i = 1;
    repeat (6) step;
    sys_rst_i = 0;
    rd(WIT_CTRL_ADDR, 8'h00);
    $display("clock, bus and reset test done");
    finish_test;
  end
endmodule
bind wit_top wit_top_properties i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .main_osc_tick_i(main_osc_tick_i), .sub_osc_tick_i(sub_osc_tick_i), .addr_i(addr_i),
  .byte_wr_i(byte_wr_i), .wr_data_i(wr_data_i), .bit_wr_i(bit_wr_i), .bit_sel_i(bit_sel_i),
  .bit_val_i(bit_val_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .watch_irq_o(watch_irq_o),
  .interval_irq_o(interval_irq_o));
